/* File: logic/serial_bus_pkg.sv */
// Constants, field positions and types shared by the serial bus byte
// access block. Assumes a 100 MHz core clock and a free-running link clock.
package serial_bus_pkg;

	// Register byte offsets in configuration space
	localparam logic [7:0] OFS_BYTE_VALUE = 8'hb0;
	localparam logic [7:0] OFS_BYTE_LOCATION = 8'hb1;
	localparam logic [7:0] OFS_TARGET_AND_DIRECTION = 8'hb2;
	localparam logic [7:0] OFS_SERIAL_CTRL = 8'hb3;

	// Control and status field positions
	localparam int CTRL_SHORT_BIT = 7;
	localparam int CTRL_BUSY_BIT = 5;
	localparam int CTRL_DETECT_BIT = 3;
	localparam int CTRL_FAST_BIT = 2;
	localparam int CTRL_ERR_BIT = 1;

	// Reset values
	localparam logic [7:0] BYTE_VALUE_RESET = 8'h00;
	localparam logic [7:0] BYTE_LOCATION_RESET = 8'h00;
	localparam logic [7:0] TARGET_RESET = 8'h00;

	// Timing: one serial bit is four quarter periods of the link clock
	localparam int LINK_CLK_KHZ = 83333;
	localparam int SCL_KHZ = 100;
	localparam int QUARTER_CYCLES = LINK_CLK_KHZ / (4 * SCL_KHZ);
	localparam int FAST_SHIFT = 4;

	// Serial engine states, Gray coded along the usual path
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_SEND = 3'b011,
		ST_ACK = 3'b010,
		ST_RECV = 3'b110,
		ST_NACK = 3'b111,
		ST_STOP = 3'b101
	} engine_state_e;

endpackage

/* File: logic/serial_req_if.sv */
// Request and answer carrier between register side and serial engine.
// Request fields stay stable from a request toggle until the done toggle.
`timescale 1ns/1ps
interface serial_req_if;
	logic req_toggle;
	logic [6:0] target_addr;
	logic direction_cmd;
	logic short_framing_sel;
	logic fast_clock;
	logic [7:0] target_byte_offset;
	logic [7:0] transfer_byte;
	logic done_toggle;
	logic [7:0] read_byte;
	logic access_error;

	modport core (
		output req_toggle, target_addr, direction_cmd, short_framing_sel,
		output fast_clock, target_byte_offset, transfer_byte,
		input done_toggle, read_byte, access_error
	);
	modport engine (
		input req_toggle, target_addr, direction_cmd, short_framing_sel,
		input fast_clock, target_byte_offset, transfer_byte,
		output done_toggle, read_byte, access_error
	);
endinterface

/* File: logic/serial_bus_engine.sv */
// Two-wire bus engine on the link clock: frames one byte access.
// Assumes request fields are held stable by the register side while busy.
`timescale 1ns/1ps
module serial_bus_engine #(
	parameter int QUARTER = serial_bus_pkg::QUARTER_CYCLES
) (
	// Clock, reset, enable
	input wire logic link_clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	// Open-drain pins
	input wire logic scl_i,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_oe_o,
	// Register side
	serial_req_if.engine req
);
	// Refuse a quarter the divider cannot count
	if (QUARTER < 2 || QUARTER > 65535) begin : g_bad_quarter
		$error("QUARTER out of range");
	end

	// The fast quarter never drops below two link cycles: the pins lag
	// by one cycle and the line synchronisers by two, so a shorter high
	// phase would sample SDA from the previous bit and skip stretching.
	localparam int Q_FAST_DIV = QUARTER >> serial_bus_pkg::FAST_SHIFT;
	localparam logic [15:0] Q_NORM = 16'(QUARTER);
	localparam logic [15:0] Q_FAST = 16'((Q_FAST_DIV < 2) ? 2 : Q_FAST_DIV);

	// Reset release and enable brought into this domain
	logic rst_s1, rst_n, ce_s1, ce_s2;
	always_ff @(posedge link_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
			ce_s1 <= 1'b0;
			ce_s2 <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
			ce_s1 <= ce_i;
			ce_s2 <= ce_s1;
		end
	end

	serial_bus_pkg::engine_state_e st, next_st;
	logic [1:0] q, next_q;
	logic [2:0] bitcnt, next_bitcnt;
	logic [1:0] step, next_step;
	logic [7:0] shreg, next_shreg;
	logic [15:0] div, next_div;
	logic scl_oe, next_scl_oe, sda_oe, next_sda_oe;
	logic [7:0] rbyte, next_rbyte;
	logic err, next_err, done_tgl, next_done_tgl;
	logic req_s1, req_s2, req_s3, next_req_s3;
	logic scl_s1, scl_s2, sda_s1, sda_s2;
	logic tick, hold, req_edge;
	logic [15:0] limit;

	assign req_edge = req_s2 ^ req_s3;
	assign limit = req.fast_clock ? Q_FAST : Q_NORM;
	// A target holding SCL low stretches the high phase
	assign hold = (q == 2'd1) && !scl_oe && !scl_s2;
	assign tick = (div == limit - 16'h0001) && !hold;

	// Next state of the framing engine
	always_comb begin
		next_st = st;
		next_q = q;
		next_bitcnt = bitcnt;
		next_step = step;
		next_shreg = shreg;
		next_div = div;
		next_rbyte = rbyte;
		next_err = err;
		next_done_tgl = done_tgl;
		next_req_s3 = req_s2;
		if (st == serial_bus_pkg::ST_IDLE) begin
			next_div = 16'h0000;
			next_q = 2'd0;
			if (req_edge) begin
				next_st = serial_bus_pkg::ST_START;
				next_step = 2'd0;
				next_err = 1'b0;
			end
		end else if (!tick) begin
			if (!hold)
				next_div = div + 16'h0001;
		end else begin
			next_div = 16'h0000;
			next_q = q + 2'd1;
			// Sample in the middle of the SCL high time
			if (q == 2'd1 && st == serial_bus_pkg::ST_ACK && sda_s2)
				next_err = 1'b1; // Missing acknowledge
			if (q == 2'd1 && st == serial_bus_pkg::ST_RECV)
				next_shreg = {shreg[6:0], sda_s2};
			if (q == 2'd3) begin
				unique case (st)
					serial_bus_pkg::ST_START: begin
						next_st = serial_bus_pkg::ST_SEND;
						next_bitcnt = 3'd0;
						// Repeated start always carries read
						if (step == 2'd3)
							next_shreg = {req.target_addr, 1'b1};
						else
							next_shreg = {req.target_addr,
								req.short_framing_sel & req.direction_cmd};
					end
					serial_bus_pkg::ST_SEND: begin
						next_shreg = {shreg[6:0], 1'b0};
						next_bitcnt = bitcnt + 3'd1;
						if (bitcnt == 3'd7)
							next_st = serial_bus_pkg::ST_ACK;
					end
					serial_bus_pkg::ST_ACK: begin
						next_bitcnt = 3'd0;
						if (err || step == 2'd2) begin
							next_st = serial_bus_pkg::ST_STOP;
						end else if (step == 2'd0 && req.short_framing_sel) begin
							// Short framing skips the offset byte
							if (req.direction_cmd) begin
								next_st = serial_bus_pkg::ST_RECV;
							end else begin
								next_st = serial_bus_pkg::ST_SEND;
								next_step = 2'd2;
								next_shreg = req.transfer_byte;
							end
						end else if (step == 2'd0) begin
							next_st = serial_bus_pkg::ST_SEND;
							next_step = 2'd1;
							next_shreg = req.target_byte_offset;
						end else if (step == 2'd1 && req.direction_cmd) begin
							next_st = serial_bus_pkg::ST_START;
							next_step = 2'd3;
						end else if (step == 2'd1) begin
							next_st = serial_bus_pkg::ST_SEND;
							next_step = 2'd2;
							next_shreg = req.transfer_byte;
						end else begin
							next_st = serial_bus_pkg::ST_RECV;
						end
					end
					serial_bus_pkg::ST_RECV: begin
						next_bitcnt = bitcnt + 3'd1;
						if (bitcnt == 3'd7) begin
							next_st = serial_bus_pkg::ST_NACK;
							next_rbyte = shreg;
						end
					end
					serial_bus_pkg::ST_NACK: next_st = serial_bus_pkg::ST_STOP;
					serial_bus_pkg::ST_STOP: begin
						next_st = serial_bus_pkg::ST_IDLE;
						next_done_tgl = ~done_tgl;
					end
					default: next_st = serial_bus_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// Pin drive: high enable pulls the line low
	always_comb begin
		next_scl_oe = 1'b0;
		next_sda_oe = 1'b0;
		unique case (st)
			serial_bus_pkg::ST_IDLE: ;
			serial_bus_pkg::ST_START: begin
				next_scl_oe = (q == 2'd3) || (q == 2'd0 && step != 2'd0);
				next_sda_oe = q[1];
			end
			serial_bus_pkg::ST_SEND: begin
				next_scl_oe = (q == 2'd0) || (q == 2'd3);
				next_sda_oe = !shreg[7];
			end
			serial_bus_pkg::ST_STOP: begin
				next_scl_oe = (q == 2'd0);
				next_sda_oe = !q[1];
			end
			default: next_scl_oe = (q == 2'd0) || (q == 2'd3);
		endcase
	end

	// Registers of the link domain; the first sync stages feed only the second
	always_ff @(posedge link_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st <= serial_bus_pkg::ST_IDLE;
			q <= 2'd0;
			bitcnt <= 3'd0;
			step <= 2'd0;
			shreg <= 8'h00;
			div <= 16'h0000;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			rbyte <= 8'h00;
			err <= 1'b0;
			done_tgl <= 1'b0;
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			req_s3 <= 1'b0;
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
		end else if (ce_s2) begin
			st <= next_st;
			q <= next_q;
			bitcnt <= next_bitcnt;
			step <= next_step;
			shreg <= next_shreg;
			div <= next_div;
			scl_oe <= next_scl_oe;
			sda_oe <= next_sda_oe;
			rbyte <= next_rbyte;
			err <= next_err;
			done_tgl <= next_done_tgl;
			req_s1 <= req.req_toggle;
			req_s2 <= req_s1;
			req_s3 <= next_req_s3;
			scl_s1 <= scl_i;
			scl_s2 <= scl_s1;
			sda_s1 <= sda_i;
			sda_s2 <= sda_s1;
		end
	end

	assign scl_oe_o = scl_oe;
	assign sda_oe_o = sda_oe;
	assign req.done_toggle = done_tgl;
	assign req.read_byte = rbyte;
	assign req.access_error = err;
endmodule

/* File: logic/serial_bus_byte_access.sv */
// Register side of the software-driven two-wire byte access master.
// Assumes configuration-space byte accesses on the core clock and a
// separate link clock for the serial engine.
`timescale 1ns/1ps
module serial_bus_byte_access #(
	parameter int QUARTER = serial_bus_pkg::QUARTER_CYCLES
) (
	// Core clock, reset, enable
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	// Configuration byte access
	input wire logic [7:0] cfg_addr_i,
	input wire logic cfg_wr_i,
	input wire logic [7:0] cfg_wdata_i,
	input wire logic cfg_rd_i,
	output logic [7:0] cfg_rdata_o,
	// Serial link
	input wire logic link_clk_i,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o
);
	serial_req_if link ();

	logic [7:0] byte_value, next_byte_value;
	logic [7:0] byte_location, next_byte_location;
	logic [7:0] target_and_direction, next_target_and_direction;
	logic short_sel, next_short_sel;
	logic detect, next_detect, fast, next_fast;
	logic busy, next_busy, err, next_err;
	logic req_tgl, next_req_tgl;
	logic done_s1, done_s2, done_s3;
	logic [7:0] rdata, next_rdata;
	logic wr_ok, done_edge;

	// Writes to request fields are dropped while an access runs,
	// so the engine never sees the fields change mid-frame.
	assign wr_ok = cfg_wr_i && !busy;
	assign done_edge = done_s2 ^ done_s3;

	function automatic logic [7:0] ctrl_view(input logic s, input logic b,
		input logic d, input logic f, input logic e);
		logic [7:0] v;
		v = 8'h00;
		v[serial_bus_pkg::CTRL_SHORT_BIT] = s;
		v[serial_bus_pkg::CTRL_BUSY_BIT] = b;
		v[serial_bus_pkg::CTRL_DETECT_BIT] = d;
		v[serial_bus_pkg::CTRL_FAST_BIT] = f;
		v[serial_bus_pkg::CTRL_ERR_BIT] = e;
		return v;
	endfunction

	// Register writes, launch and completion
	always_comb begin
		next_byte_value = byte_value;
		next_byte_location = byte_location;
		next_target_and_direction = target_and_direction;
		next_short_sel = short_sel;
		next_detect = detect;
		next_fast = fast;
		next_busy = busy;
		next_err = err;
		next_req_tgl = req_tgl;
		next_rdata = rdata;
		if (wr_ok && cfg_addr_i == serial_bus_pkg::OFS_BYTE_VALUE)
			next_byte_value = cfg_wdata_i;
		if (wr_ok && cfg_addr_i == serial_bus_pkg::OFS_BYTE_LOCATION)
			next_byte_location = cfg_wdata_i;
		if (wr_ok && cfg_addr_i == serial_bus_pkg::OFS_TARGET_AND_DIRECTION) begin
			next_target_and_direction = cfg_wdata_i;
			next_busy = 1'b1;
			next_req_tgl = ~req_tgl;
		end
		if (wr_ok && cfg_addr_i == serial_bus_pkg::OFS_SERIAL_CTRL) begin
			next_short_sel = cfg_wdata_i[serial_bus_pkg::CTRL_SHORT_BIT];
			next_detect = cfg_wdata_i[serial_bus_pkg::CTRL_DETECT_BIT];
			next_fast = cfg_wdata_i[serial_bus_pkg::CTRL_FAST_BIT];
		end
		// Write-one-to-clear works even while busy
		if (cfg_wr_i && cfg_addr_i == serial_bus_pkg::OFS_SERIAL_CTRL &&
			cfg_wdata_i[serial_bus_pkg::CTRL_ERR_BIT])
			next_err = 1'b0;
		if (done_edge) begin
			next_busy = 1'b0;
			// Set wins over a clear in the same cycle
			if (link.access_error)
				next_err = 1'b1;
			if (target_and_direction[0] && !link.access_error)
				next_byte_value = link.read_byte;
		end
		if (cfg_rd_i) begin
			unique case (cfg_addr_i)
				serial_bus_pkg::OFS_BYTE_VALUE: next_rdata = byte_value;
				serial_bus_pkg::OFS_BYTE_LOCATION: next_rdata = byte_location;
				serial_bus_pkg::OFS_TARGET_AND_DIRECTION:
					next_rdata = target_and_direction;
				serial_bus_pkg::OFS_SERIAL_CTRL:
					next_rdata = ctrl_view(short_sel, busy, detect, fast, err);
				default: next_rdata = 8'h00;
			endcase
		end
	end

	// Core domain registers; done_s1 feeds only done_s2
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			byte_value <= serial_bus_pkg::BYTE_VALUE_RESET;
			byte_location <= serial_bus_pkg::BYTE_LOCATION_RESET;
			target_and_direction <= serial_bus_pkg::TARGET_RESET;
			short_sel <= 1'b0;
			detect <= 1'b0;
			fast <= 1'b0;
			busy <= 1'b0;
			err <= 1'b0;
			req_tgl <= 1'b0;
			done_s1 <= 1'b0;
			done_s2 <= 1'b0;
			done_s3 <= 1'b0;
			rdata <= 8'h00;
		end else if (ce_i) begin
			byte_value <= next_byte_value;
			byte_location <= next_byte_location;
			target_and_direction <= next_target_and_direction;
			short_sel <= next_short_sel;
			detect <= next_detect;
			fast <= next_fast;
			busy <= next_busy;
			err <= next_err;
			req_tgl <= next_req_tgl;
			done_s1 <= link.done_toggle;
			done_s2 <= done_s1;
			done_s3 <= done_s2;
			rdata <= next_rdata;
		end
	end

	// Request fields handed to the engine, stable while busy
	assign link.req_toggle = req_tgl;
	assign link.target_addr = target_and_direction[7:1];
	assign link.direction_cmd = target_and_direction[0];
	assign link.short_framing_sel = short_sel;
	assign link.fast_clock = fast;
	assign link.target_byte_offset = byte_location;
	assign link.transfer_byte = byte_value;

	serial_bus_engine #(
		.QUARTER(QUARTER)
	) engine (
		.link_clk_i(link_clk_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.scl_i(scl_i),
		.scl_oe_o(scl_oe_o),
		.sda_i(sda_i),
		.sda_oe_o(sda_oe_o),
		.req(link)
	);

	// Open-drain lines only ever pull low
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign cfg_rdata_o = rdata;
endmodule

/* File: verification/serial_bus_byte_access_assertions.sv */
// Checker for the byte access block: register port and pin timing.
// Sees only the top module's ports; attached by the bind at the foot.
`timescale 1ns/1ps
module serial_bus_byte_access_assertions #(
	parameter int QUARTER = serial_bus_pkg::QUARTER_CYCLES
) (
	// Core side
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic [7:0] cfg_addr_i,
	input wire logic cfg_wr_i,
	input wire logic cfg_rd_i,
	input wire logic [7:0] cfg_rdata_o,
	// Link side
	input wire logic link_clk_i,
	input wire logic scl_oe_o,
	input wire logic sda_oe_o
);
	localparam int START_MAX = 300;
	int low_cnt;
	logic rd_ok;

	// Read taken at this edge
	assign rd_ok = cfg_rd_i && ce_i;

	// Run length of SCL pulled low; a stuck divider shows up here
	always_ff @(posedge link_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			low_cnt <= 0;
		else
			low_cnt <= scl_oe_o ? low_cnt + 1 : 0;
	end

	property p_busy;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		cfg_wr_i && ce_i && cfg_addr_i == 8'hb2 ##2
		rd_ok && cfg_addr_i == 8'hb3 |=> cfg_rdata_o[5];
	endproperty
	a_busy: assert property (p_busy)
		else $error("busy flag not set after launch");

	property p_unmapped;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		rd_ok && (cfg_addr_i < 8'hb0 || cfg_addr_i > 8'hb3)
		|=> cfg_rdata_o == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");

	property p_reserved;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		rd_ok && cfg_addr_i == 8'hb3
		|=> {cfg_rdata_o[6], cfg_rdata_o[4], cfg_rdata_o[0]} == 3'h0;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved status bits set");

	property p_hold;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		!rd_ok |=> $stable(cfg_rdata_o);
	endproperty
	a_hold: assert property (p_hold)
		else $error("read data changed without a read");

	property p_core_reset;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		$rose(reset_n_i) |-> cfg_rdata_o == 8'h00;
	endproperty
	a_core_reset: assert property (p_core_reset)
		else $error("read data not clear after reset");

	property p_link_reset;
		@(posedge link_clk_i) disable iff (!reset_n_i)
		$rose(reset_n_i) |-> !scl_oe_o && !sda_oe_o;
	endproperty
	a_link_reset: assert property (p_link_reset)
		else $error("pins driven after reset");

	property p_start;
		@(posedge link_clk_i) disable iff (!reset_n_i)
		$rose(sda_oe_o) && !scl_oe_o |-> ##[1:START_MAX] scl_oe_o;
	endproperty
	a_start: assert property (p_start)
		else $error("no clock after start");

	property p_stop;
		@(posedge link_clk_i) disable iff (!reset_n_i)
		$fell(sda_oe_o) && !scl_oe_o |-> !scl_oe_o [*3];
	endproperty
	a_stop: assert property (p_stop)
		else $error("clock pulled too soon after stop");

	property p_low_len;
		@(posedge link_clk_i) disable iff (!reset_n_i)
		low_cnt <= 2 * QUARTER + 4;
	endproperty
	a_low_len: assert property (p_low_len)
		else $error("clock held low too long");

	// Main scenarios reached
	c_start: cover property (@(posedge link_clk_i) $rose(sda_oe_o));
	c_launch: cover property (@(posedge core_clk_i)
		cfg_wr_i && cfg_addr_i == 8'hb2);
	c_err: cover property (@(posedge core_clk_i) cfg_rdata_o[1]);
endmodule

bind serial_bus_byte_access serial_bus_byte_access_assertions #(
	.QUARTER(QUARTER)
) serial_bus_byte_access_assertions_i (.core_clk_i, .reset_n_i, .ce_i,
	.cfg_addr_i, .cfg_wr_i, .cfg_rd_i, .cfg_rdata_o, .link_clk_i,
	.scl_oe_o, .sda_oe_o);

/* File: verification/serial_target_model.sv */
// Behavioural two-wire target: acks, records bytes, answers one read.
// Assumes pulled-up wire levels built by the bench from all pull-downs.
`timescale 1ns/1ps
module serial_target_model #(
	parameter logic [6:0] ADDR = 7'h50
) (
	// Wire levels
	input wire logic scl_i,
	input wire logic sda_i,
	// Behaviour controls
	input wire logic nack_i,
	input wire logic stretch_i,
	input wire logic [7:0] rd_byte_i,
	// Pull-downs
	output logic scl_pull_o,
	output logic sda_pull_o
);
	logic [7:0] sh;
	logic first = 1'b0;
	logic tx = 1'b0;
	int cnt = 0;
	int n_start = 0;
	logic [7:0] got [$];

	initial begin
		scl_pull_o = 1'b0;
		sda_pull_o = 1'b0;
	end

	// Start or repeated start restarts byte framing
	always @(negedge sda_i) if (scl_i) begin
		cnt = 0;
		first = 1'b1;
		tx = 1'b0;
		n_start++;
	end

	// Stop ends any transmit
	always @(posedge sda_i) if (scl_i)
		tx = 1'b0;

	// Sample on rising clock; a master nack ends transmit
	always @(posedge scl_i) begin
		if (cnt < 8)
			sh = {sh[6:0], sda_i};
		else if (tx && sda_i)
			tx = 1'b0;
		cnt = (cnt + 1) % 9;
	end

	// Change drive only while the clock is low; stretching holds it there
	always @(negedge scl_i) begin
		sda_pull_o = 1'b0;
		if (cnt == 8 && !tx) begin
			got.push_back(sh);
			sda_pull_o = !nack_i && (!first || sh[7:1] == ADDR);
			if (first)
				tx = sh[0] && sda_pull_o;
			first = 1'b0;
		end else if (tx && cnt < 8)
			sda_pull_o = !rd_byte_i[7 - cnt];
		if (stretch_i) begin
			scl_pull_o = 1'b1;
			#300;
			scl_pull_o = 1'b0;
		end
	end
endmodule

/* File: verification/serial_bus_byte_access_bench.sv */
// Self-checking bench for the byte access block with a target model.
// Assumes the pull-ups are modelled by the wire assignments below.
`timescale 1ns/1ps
module serial_bus_byte_access_bench;
	localparam logic [6:0] TGT = 7'h50;
	logic clk, lclk, rst_n, wr, rd, nack, stretch;
	logic ce, scl_d, sda_d;
	logic scl_oe, sda_oe, scl_pull, sda_pull;
	logic [7:0] addr, wdata, rdata, d, rd_byte;
	int n_fail = 0;
	int n_compared = 0;
	logic [23:0] rows [6] = '{24'hb0a5a5, 24'hb13c3c, 24'hb3ff8c,
		24'hb30000, 24'hb4ff00, 24'ha6ff00};
	wire scl_w = !(scl_oe | scl_pull);
	wire sda_w = !(sda_oe | sda_pull);

	serial_bus_byte_access #(.QUARTER(4)) serial_bus_byte_access_i (
		.core_clk_i(clk), .reset_n_i(rst_n), .ce_i(ce),
		.cfg_addr_i(addr), .cfg_wr_i(wr), .cfg_wdata_i(wdata),
		.cfg_rd_i(rd), .cfg_rdata_o(rdata), .link_clk_i(lclk),
		.scl_i(scl_w), .scl_o(scl_d), .scl_oe_o(scl_oe),
		.sda_i(sda_w), .sda_o(sda_d), .sda_oe_o(sda_oe));

	serial_target_model #(.ADDR(TGT)) serial_target_model_i (
		.scl_i(scl_w), .sda_i(sda_w), .nack_i(nack),
		.stretch_i(stretch), .rd_byte_i(rd_byte),
		.scl_pull_o(scl_pull), .sda_pull_o(sda_pull));

	// Core and link clocks, unrelated in phase
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		lclk = 1'b0;
		#3.7;
		forever #6 lclk = ~lclk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk) #1;
		addr = a;
		wdata = v;
		wr = 1'b1;
		@(posedge clk) #1;
		wr = 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk) #1;
		addr = a;
		rd = 1'b1;
		@(posedge clk) #1;
		rd = 1'b0;
		v = rdata;
	endtask

	// Bounded poll of the busy flag
	task automatic wait_idle;
		d = 8'h20;
		for (int i = 0; i < 4000 && d[5] !== 1'b0; i++)
			rd_reg(8'hb3, d);
		chk({7'h00, d[5]}, 8'h00);
	endtask

	// Bytes seen by the target since the last check
	task automatic frame(input logic [7:0] b0, b1, b2, input int n);
		chk(8'(serial_target_model_i.got.size()), 8'(n));
		for (int i = 0; i < n; i++)
			chk(serial_target_model_i.got[i], i == 0 ? b0 : i == 1 ? b1 : b2);
		serial_target_model_i.got.delete();
	endtask

	task automatic wrap_up;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		#400000;
		n_fail++;
		wrap_up();
	end

	initial begin
		{rst_n, wr, rd, nack, stretch} = 5'h00;
		ce = 1'b1;
		addr = 8'h00;
		wdata = 8'h00;
		rd_byte = 8'hc3;
		repeat (6) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge clk);
		// Reset values
		rd_reg(8'hb0, d);
		chk(d, serial_bus_pkg::BYTE_VALUE_RESET);
		rd_reg(8'hb1, d);
		chk(d, 8'h00);
		rd_reg(8'hb2, d);
		chk(d, serial_bus_pkg::TARGET_RESET);
		rd_reg(8'hb3, d);
		chk(d, 8'h00);
		// Write then read back, unmapped places read zero
		foreach (rows[i]) begin
			wr_reg(rows[i][23:16], rows[i][15:8]);
			rd_reg(rows[i][23:16], d);
			chk(d, rows[i][7:0]);
		end
		// Byte write; a data write while busy is ignored
		wr_reg(8'hb0, 8'h5a);
		wr_reg(8'hb1, 8'h12);
		wr_reg(8'hb2, {TGT, 1'b0});
		rd_reg(8'hb3, d);
		chk(d, 8'h20);
		wr_reg(8'hb0, 8'h77);
		wait_idle();
		frame(8'ha0, 8'h12, 8'h5a, 3);
		// Open-drain lines may only ever pull low
		chk({6'h00, scl_d, sda_d}, 8'h00);
		rd_reg(8'hb0, d);
		chk(d, 8'h5a);
		// Byte read against a slow, stretching target
		stretch = 1'b1;
		wr_reg(8'hb1, 8'h34);
		wr_reg(8'hb2, {TGT, 1'b1});
		wait_idle();
		frame(8'ha0, 8'h34, 8'ha1, 3);
		chk(8'(serial_target_model_i.n_start), 8'h03);
		rd_reg(8'hb0, d);
		chk(d, 8'hc3);
		stretch = 1'b0;
		// Short framing at the fast test rate
		wr_reg(8'hb3, 8'h84);
		wr_reg(8'hb0, 8'h66);
		wr_reg(8'hb2, {TGT, 1'b0});
		wait_idle();
		frame(8'ha0, 8'h66, 8'h00, 2);
		rd_byte = 8'h9e;
		wr_reg(8'hb2, {TGT, 1'b1});
		wait_idle();
		frame(8'ha1, 8'h00, 8'h00, 1);
		rd_reg(8'hb0, d);
		chk(d, 8'h9e);
		// Missing acknowledge: sticky error, data kept, clear by one
		wr_reg(8'hb3, 8'h00);
		nack = 1'b1;
		wr_reg(8'hb0, 8'h11);
		wr_reg(8'hb2, {TGT, 1'b1});
		wait_idle();
		rd_reg(8'hb3, d);
		chk(d, 8'h02);
		rd_reg(8'hb0, d);
		chk(d, 8'h11);
		wr_reg(8'hb3, 8'h00);
		rd_reg(8'hb3, d);
		chk(d, 8'h02);
		wr_reg(8'hb3, 8'h02);
		rd_reg(8'hb3, d);
		chk(d, 8'h00);
		nack = 1'b0;
		// Clock enable low freezes the registers: the write is lost
		ce = 1'b0;
		wr_reg(8'hb1, 8'h55);
		ce = 1'b1;
		rd_reg(8'hb1, d);
		chk(d, 8'h34);
		// Reset in mid-frame
		wr_reg(8'hb2, {TGT, 1'b0});
		repeat (60) @(posedge clk);
		#1 rst_n = 1'b0;
		repeat (6) @(posedge clk);
		#1 rst_n = 1'b1;
		rd_reg(8'hb3, d);
		chk(d, 8'h00);
		rd_reg(8'hb1, d);
		chk(d, 8'h00);
		wrap_up();
	end
endmodule
